// ==== src/tsq_top.sv ====
// Trigger sequencer configuration registers, APB slave and step timing engine
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tsq_defs.svh"
module tsq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] clk_src_pins,
  input wire logic [15:0] trig_in_pins,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  output logic cmd_done,
  output logic jump_taken,
  output logic [4:0] jump_target,
  output logic adc_sample_trigger,
  output logic [3:0] capture_sync,
  output logic [3:0] compare_clock,
  output logic [3:0] compare_sync,
  output logic irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] cst_q; // Control and status
  logic [15:0] con_q; // Clock control
  logic [15:0] bte_q; // Broadcast enables
  logic [15:0] t0lim_q; // Timer0 limit
  logic [15:0] t1lim_q; // Timer1 limit
  logic [15:0] sdlim_q; // Step delay limit
  logic [15:0] c0lim_q; // Counter0 limit
  logic [2:0] istat_q; // Sticky events
  logic [2:0] imask_q; // Event enables
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  tsq_pkg::tsq_state_t state_q;
  tsq_pkg::tsq_state_t state_d;
  logic sd_en_q; // Step delay enabled by control command
  logic skip_q; // Current command bypasses the delay
  logic [3:0] opt_q; // Option of the running command
  logic lvl_q; // Wait target level, 1 for rising
  logic [15:0] tcnt_q; // Timer and delay counter
  logic [9:0] wcnt_q; // Watchdog counter
  logic [15:0] c0_q; // Counter0
  logic swt_p_q; // Soft trigger history
  logic [15:0] in_meta_q; // First stage, read only by in_sync_q
  logic [15:0] in_sync_q;
  logic [15:0] in_prev_q;
  logic cmd_ready_q;
  logic cmd_done_q;
  logic jump_taken_q;
  logic [4:0] jump_target_q;
  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  wire run = cst_q[`TSQ_CST_EN] & cst_q[`TSQ_CST_STRT];
  wire swt = cst_q[`TSQ_CST_SWT];
  wire [1:0] itm = cst_q[1:0];
  wire [2:0] clk_sel = con_q[15:13];
  wire [4:0] clk_div = con_q[12:8];
  wire [3:0] pwd = con_q[7:4];
  wire [2:0] wdt = con_q[2:0];
  wire tick;
  // Watchdog limit is 8 shifted left by field minus one
  function automatic logic [9:0] wdt_limit(input logic [2:0] f);
    wdt_limit = `TSQ_WDT_BASE << (f - 3'h1);
  endfunction
  // Match of a bus address to one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire s_cst = hit(paddr, `TSQ_OFF_CST);
  wire s_con = hit(paddr, `TSQ_OFF_CON);
  wire s_bte = hit(paddr, `TSQ_OFF_BTE);
  wire s_t0 = hit(paddr, `TSQ_OFF_T0LIM);
  wire s_t1 = hit(paddr, `TSQ_OFF_T1LIM);
  wire s_sd = hit(paddr, `TSQ_OFF_SDLIM);
  wire s_c0 = hit(paddr, `TSQ_OFF_C0LIM);
  wire s_is = hit(paddr, `TSQ_OFF_ISTAT);
  wire s_im = hit(paddr, `TSQ_OFF_IMASK);
  wire mapped = s_cst | s_con | s_bte | s_t0 | s_t1 | s_sd | s_c0 | s_is | s_im;
  wire acc_wait = psel & penable & ~pready_q;
  wire wr_fire = psel & penable & pready_q & pwrite & mapped;
  wire wr_cfg = wr_fire & ~run;
  wire [15:0] wd = pwdata[15:0];
  wire [15:0] rd_mux =
    s_cst ? cst_q :
    s_con ? con_q :
    s_bte ? bte_q :
    s_t0 ? t0lim_q :
    s_t1 ? t1lim_q :
    s_sd ? sdlim_q :
    s_c0 ? c0lim_q :
    s_is ? {13'h0000, istat_q} :
    s_im ? {13'h0000, imask_q} : 16'h0000;
  // One wait state: answer is registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= acc_wait;
      pslverr_q <= acc_wait & ~mapped;
      if (acc_wait) begin
        prdata_q <= (pwrite | ~mapped) ? 32'h00000000 : {16'h0000, rd_mux};
      end
    end
  end
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire accept = cmd_valid & cmd_ready_q;
  wire [3:0] op = cmd_byte[7:4];
  wire [3:0] opt = cmd_byte[3:0];
  wire is_ctrl = (op == `TSQ_OP_CTRL);
  wire is_wait = (op == `TSQ_OP_WHI) | (op == `TSQ_OP_WLO);
  wire is_jc0 = (op[3:1] == `TSQ_OP_JC0);
  wire bcast_fire = accept & is_ctrl & (opt == `TSQ_OPT_BCAST);
  wire c0_eq = (c0_q == c0lim_q);
  wire in_bit = in_sync_q[opt_q];
  wire in_old = in_prev_q[opt_q];
  // Level mode looks at the level, edge mode needs a transition
  wire in_hit = itm[1] ? (in_bit == lvl_q) : ((in_bit == lvl_q) && (in_old != lvl_q));
  wire [15:0] tlim = opt_q[0] ? t1lim_q : t0lim_q;
  wire waiting = (state_q == tsq_pkg::TSQ_WIN) | (state_q == tsq_pkg::TSQ_TMR) |
                 (state_q == tsq_pkg::TSQ_SWT);
  wire wdt_trip = waiting && tick && (wdt != 3'h0) && (wcnt_q == wdt_limit(wdt) - 10'h001);
  // After a command either wait out the step delay or finish now
  wire tsq_pkg::tsq_state_t after = (sd_en_q && !skip_q) ? tsq_pkg::TSQ_DLY : tsq_pkg::TSQ_DONE;
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      tsq_pkg::TSQ_IDLE: begin
        if (accept) begin
          if (is_wait) begin
            state_d = tsq_pkg::TSQ_WIN;
          end else if (is_ctrl && ((opt == `TSQ_OPT_T0) || (opt == `TSQ_OPT_T1))) begin
            state_d = tsq_pkg::TSQ_TMR;
          end else if (is_ctrl && (opt == `TSQ_OPT_SWT)) begin
            state_d = tsq_pkg::TSQ_SWT;
          end else if (sd_en_q) begin
            state_d = tsq_pkg::TSQ_DLY;
          end else begin
            state_d = tsq_pkg::TSQ_DONE;
          end
        end
      end
      tsq_pkg::TSQ_WIN: begin
        if (in_hit) begin
          state_d = after;
        end
      end
      tsq_pkg::TSQ_TMR: begin
        if (tick && (tcnt_q == tlim)) begin
          state_d = after;
        end
      end
      tsq_pkg::TSQ_SWT: begin
        if (swt && !swt_p_q) begin
          state_d = after;
        end
      end
      tsq_pkg::TSQ_DLY: begin
        if (tick && (tcnt_q == sdlim_q)) begin
          state_d = tsq_pkg::TSQ_DONE;
        end
      end
      tsq_pkg::TSQ_DONE: state_d = tsq_pkg::TSQ_IDLE;
      default: state_d = tsq_pkg::TSQ_IDLE;
    endcase
    // Watchdog or stop abandons the command
    if (wdt_trip) begin
      state_d = tsq_pkg::TSQ_DONE;
    end
    if (!run) begin
      state_d = tsq_pkg::TSQ_IDLE;
    end
  end
  // ----------------------------------------------------------------
  // Engine registers
  // ----------------------------------------------------------------
  // State, per-command latches and handshake flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tsq_pkg::TSQ_IDLE;
      skip_q <= 1'b0;
      opt_q <= 4'h0;
      lvl_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      cmd_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        skip_q <= is_wait & itm[0];
        opt_q <= opt;
        lvl_q <= (op == `TSQ_OP_WHI);
      end
      cmd_ready_q <= (state_d == tsq_pkg::TSQ_IDLE) && run && !accept;
      cmd_done_q <= (state_d == tsq_pkg::TSQ_DONE) && (state_q != tsq_pkg::TSQ_DONE);
    end
  end
  // Step delay enable, counters and jump result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_en_q <= 1'b0;
      tcnt_q <= 16'h0000;
      wcnt_q <= 10'h000;
      c0_q <= 16'h0000;
      jump_taken_q <= 1'b0;
      jump_target_q <= 5'h00;
    end else begin
      if (accept && is_ctrl && (opt == `TSQ_OPT_SD_ON)) begin
        sd_en_q <= 1'b1;
      end else if (accept && is_ctrl && (opt == `TSQ_OPT_SD_OFF)) begin
        sd_en_q <= 1'b0;
      end
      // Timer and delay share one counter, cleared on each state change
      if (state_d != state_q) begin
        tcnt_q <= 16'h0000;
      end else if (tick) begin
        tcnt_q <= tcnt_q + 16'h0001;
      end
      if (!waiting || (state_d != state_q)) begin
        wcnt_q <= 10'h000;
      end else if (tick) begin
        wcnt_q <= wcnt_q + 10'h001;
      end
      if (accept && is_jc0) begin
        c0_q <= c0_eq ? 16'h0000 : c0_q + 16'h0001;
        jump_taken_q <= !c0_eq;
        jump_target_q <= {cmd_byte[4], opt};
      end
    end
  end
  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Config writes other than control and the event enables land only while the engine is not running (EN and STRT not both set)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst_q <= `TSQ_REG_RST;
      con_q <= `TSQ_REG_RST;
      bte_q <= `TSQ_REG_RST;
      t0lim_q <= `TSQ_REG_RST;
      t1lim_q <= `TSQ_REG_RST;
      sdlim_q <= `TSQ_REG_RST;
      c0lim_q <= `TSQ_REG_RST;
      imask_q <= 3'h0;
      swt_p_q <= 1'b0;
    end else begin
      swt_p_q <= swt;
      // Control stays writable so software can always stop the engine
      if (wr_fire && s_cst) begin
        cst_q <= (wd & `TSQ_CST_WMASK) | (cst_q & ~`TSQ_CST_WMASK);
      end
      // Time-out flag set wins over a control write in the same cycle
      if (wdt_trip) begin
        cst_q[`TSQ_CST_WDTO] <= 1'b1;
      end
      if (wr_cfg && s_con) con_q <= wd & `TSQ_CON_WMASK;
      if (wr_cfg && s_bte) bte_q <= wd & `TSQ_BTE_WMASK;
      if (wr_cfg && s_t0) t0lim_q <= wd;
      if (wr_cfg && s_t1) t1lim_q <= wd;
      if (wr_cfg && s_sd) sdlim_q <= wd;
      if (wr_cfg && s_c0) c0lim_q <= wd;
      if (wr_fire && s_im) imask_q <= wd[2:0];
    end
  end
  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire [2:0] ev = {cmd_done_q, bcast_fire, wdt_trip};
  wire [2:0] w1c = (wr_fire && s_is) ? wd[2:0] : 3'h0;
  // Set wins over a clear landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~w1c) | ev;
      irq_q <= |(((istat_q & ~w1c) | ev) & imask_q);
    end
  end
  // ----------------------------------------------------------------
  // Trigger input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta_q <= 16'h0000;
      in_sync_q <= 16'h0000;
      in_prev_q <= 16'h0000;
    end else begin
      in_meta_q <= trig_in_pins;
      in_sync_q <= in_meta_q;
      in_prev_q <= in_sync_q;
    end
  end
  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  wire [12:0] trig_q;
  tsq_clkdiv u_clkdiv (
    .pclk(pclk),
    .presetn(presetn),
    .src_pins(clk_src_pins),
    .sel(clk_sel),
    .div(clk_div),
    .tick_q(tick)
  );
  // Cleared enable bits load zero, so they emit nothing
  tsq_pulse #(.W(13)) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .fire(bcast_fire),
    .bits(bte_q[12:0]),
    .width(pwd),
    .tick(tick),
    .pulse_q(trig_q)
  );
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cmd_ready = cmd_ready_q;
  assign cmd_done = cmd_done_q;
  assign jump_taken = jump_taken_q;
  assign jump_target = jump_target_q;
  assign adc_sample_trigger = trig_q[12];
  assign capture_sync = trig_q[11:8];
  assign compare_clock = trig_q[7:4];
  assign compare_sync = trig_q[3:0];
  assign irq = irq_q;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_win_exit;
    (state_q == tsq_pkg::TSQ_WIN) && in_hit && run && !wdt_trip;
  endsequence
  a_skip_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (s_win_exit and skip_q) |=> (state_q == tsq_pkg::TSQ_DONE) && cmd_done_q)
    else $error("delay not skipped");
  a_exec_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (s_win_exit and !skip_q and sd_en_q) |=> state_q == tsq_pkg::TSQ_DLY)
    else $error("delay not executed");
  a_swt_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !(is_ctrl && (opt == `TSQ_OPT_SWT)) |=> state_q != tsq_pkg::TSQ_SWT)
    else $error("soft trigger wait entered");
  a_bcast_out: assert property (@(posedge pclk) disable iff (!presetn)
    bcast_fire |=> trig_q == $past(bte_q[12:0]))
    else $error("broadcast outputs wrong");
  a_oc_clock: assert property (@(posedge pclk) disable iff (!presetn)
    bcast_fire && (bte_q[7:4] == 4'h0) |=> compare_clock == 4'h0)
    else $error("compare clock without enable");
  a_bte_only: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(|trig_q) |-> $past(accept) && ($past(cmd_byte) == 8'h0F))
    else $error("broadcast without its command");
  a_cfg_lock: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && run |=> $stable(bte_q) && $stable(sdlim_q) && $stable(con_q))
    else $error("locked register written");
  a_tmr_limit: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == tsq_pkg::TSQ_TMR) && ($past(state_q) == tsq_pkg::TSQ_TMR) && run &&
    (state_d != tsq_pkg::TSQ_TMR) && !wdt_trip |-> tcnt_q == tlim)
    else $error("timer wait left early");
  a_dly_total: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == tsq_pkg::TSQ_DLY) && (state_d == tsq_pkg::TSQ_DONE) |-> tcnt_q == sdlim_q)
    else $error("step delay not limit plus one");
  a_c0_count: assert property (@(posedge pclk) disable iff (!presetn)
    accept && is_jc0 && !c0_eq |=> jump_taken_q && (c0_q == $past(c0_q) + 16'h0001))
    else $error("counter0 jump wrong");
  a_wdt_time: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_trip |-> (wcnt_q == wdt_limit(wdt) - 10'h001) ##1 cst_q[`TSQ_CST_WDTO])
    else $error("watchdog timed out wrongly");
endmodule
`default_nettype wire

// ==== src/tsq_defs.svh ====
// Register offsets, field positions, masks and reset values of the trigger sequencer
`ifndef TSQ_DEFS_SVH
`define TSQ_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TSQ_OFF_CST 8'h00
`define TSQ_OFF_CON 8'h04
`define TSQ_OFF_BTE 8'h08
`define TSQ_OFF_T0LIM 8'h0C
`define TSQ_OFF_T1LIM 8'h10
`define TSQ_OFF_SDLIM 8'h14
`define TSQ_OFF_C0LIM 8'h18
`define TSQ_OFF_ISTAT 8'h1C
`define TSQ_OFF_IMASK 8'h20
// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define TSQ_CST_EN 15
`define TSQ_CST_SWT 10
`define TSQ_CST_STRT 7
`define TSQ_CST_WDTO 6
`define TSQ_CST_WMASK 16'h8483
`define TSQ_CON_WMASK 16'hFFF7
`define TSQ_BTE_WMASK 16'h1FFF
`define TSQ_REG_RST 16'h0000
`define TSQ_INT_W 3
`define TSQ_INT_WDT 0
`define TSQ_INT_BCAST 1
`define TSQ_INT_DONE 2
// ----------------------------------------------------------------
// Step command encodings
// ----------------------------------------------------------------
`define TSQ_OP_CTRL 4'h0
`define TSQ_OP_WHI 4'h4
`define TSQ_OP_WLO 4'h5
`define TSQ_OP_JC0 3'h6
`define TSQ_OPT_SD_OFF 4'h2
`define TSQ_OPT_SD_ON 4'h6
`define TSQ_OPT_T0 4'h8
`define TSQ_OPT_T1 4'h9
`define TSQ_OPT_SWT 4'hB
`define TSQ_OPT_BCAST 4'hF
`define TSQ_WDT_BASE 10'h008
`endif

// ==== src/tsq_pkg.sv ====
// Types shared by the trigger sequencer files
package tsq_pkg;
  // ----------------------------------------------------------------
  // Step engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TSQ_IDLE = 3'b000,
    TSQ_WIN = 3'b001,
    TSQ_TMR = 3'b010,
    TSQ_SWT = 3'b011,
    TSQ_DLY = 3'b100,
    TSQ_DONE = 3'b101
  } tsq_state_t;
endpackage

// ==== src/tsq_clkdiv.sv ====
// Sequencer clock source selection and divider producing a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module tsq_clkdiv (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] src_pins,
  input wire logic [2:0] sel,
  input wire logic [4:0] div,
  output logic tick_q
);
  // ----------------------------------------------------------------
  // Source synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [7:0] meta_q; // First stage, read only by sync_q
  logic [7:0] sync_q; // Second stage
  logic [7:0] prev_q; // Edge history
  logic [4:0] cnt_q; // Source edges seen
  wire [7:0] rise = sync_q & ~prev_q;
  // Source 0 is the bus clock itself, so it gives an edge every cycle
  wire src_edge = (sel == 3'h0) ? 1'b1 : rise[sel];
  wire wrap = src_edge && (cnt_q == div);
  // Sample pins, count edges, divide by div plus one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
      prev_q <= 8'h00;
      cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      meta_q <= src_pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
      if (src_edge) begin
        cnt_q <= wrap ? 5'h00 : cnt_q + 5'h01;
      end
      tick_q <= wrap;
    end
  end
endmodule
`default_nettype wire

// ==== src/tsq_pulse.sv ====
// Stretches a vector of trigger outputs to a programmed number of sequencer ticks
`timescale 1ns/1ps
`default_nettype none
module tsq_pulse #(
  parameter int W = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic [W-1:0] bits,
  input wire logic [3:0] width,
  input wire logic tick,
  output logic [W-1:0] pulse_q
);
  // ----------------------------------------------------------------
  // Width counter
  // ----------------------------------------------------------------
  logic [3:0] cnt_q; // Ticks still to hold
  // Load on fire, drop after width plus one ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= '0;
      cnt_q <= 4'h0;
    end else if (fire) begin
      pulse_q <= bits;
      cnt_q <= width;
    end else if (tick && (pulse_q != '0)) begin
      if (cnt_q == 4'h0) begin
        pulse_q <= '0;
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tsq_periph_model.sv ====
// Peripheral-side model counting trigger pulses from the sequencer
`timescale 1ns/1ps
`default_nettype none
module tsq_periph_model (
  input wire logic pclk,
  input wire logic [12:0] trig,
  output logic [7:0] cnt [13]
);
  logic [12:0] prev_q = 13'h0000; // Last seen trigger levels
  // Counters start clear, like freshly reset peripherals
  initial begin
    foreach (cnt[i]) cnt[i] = 8'h00;
  end
  // Each unit reacts to a rising edge only, so a wide pulse counts once
  always @(posedge pclk) begin
    prev_q <= trig;
    for (int i = 0; i < 13; i++) begin
      if (trig[i] && !prev_q[i]) begin
        cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/trigger_sequencer_config_test.sv ====
// Self-checking bench for the trigger sequencer top level
`timescale 1ns/1ps
`default_nettype none
module trigger_sequencer_config_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, cmd_valid = 1'b0;
  logic [7:0] paddr = 8'h00, cmd_byte = 8'h00, clk_src_pins = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h149DE;
  logic [15:0] trig_in_pins = 16'h0000, bte_v, lim [4];
  logic pready, pslverr, cmd_ready, cmd_done, jump_taken, irq, adc_t;
  logic [4:0] jump_target;
  logic [3:0] cap_s, cmp_c, cmp_s;
  logic [7:0] cnt [13];
  logic [32:0] exp_q [$]; // Expected {pslverr, prdata} per read
  int n_mismatch = 0, checks = 0, l0, l1, lat [4];
  always #2.5 pclk = ~pclk;
  tsq_top u_tsq_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_src_pins(clk_src_pins), .trig_in_pins(trig_in_pins),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .jump_taken(jump_taken), .jump_target(jump_target),
    .adc_sample_trigger(adc_t), .capture_sync(cap_s), .compare_clock(cmp_c),
    .compare_sync(cmp_s), .irq(irq));
  tsq_periph_model u_tsq_periph_model (.pclk(pclk),
    .trig({adc_t, cap_s, cmp_c, cmp_s}), .cnt(cnt));
  // ----------------------------
  // Shared tasks
  // ----------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle cycle follows so psel never toggles twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 16'h0000);
  endtask
  // Offers one command; l counts cycles from the accept edge to done
  task automatic cmd(input logic [7:0] b, output int l);
    int n;
    n = 0;
    l = 0;
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    do begin
      @(negedge pclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    @(posedge pclk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge pclk);
      l++;
    end while (cmd_done !== 1'b1 && l < 200);
    @(posedge pclk);
    if (n >= 200 || l >= 200) n_mismatch++;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Read results are taken at the edge where pready is sampled
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // ----------------------------
  // Scenarios
  // ----------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 33'h0);
    rd(8'h24, {1'b1, 32'h0});
    apb(1'b1, 8'h04, 16'hFFFF);
    rd(8'h04, 33'hFFF7);
    apb(1'b1, 8'h04, 16'h0000);
    bte_v = rnd();
    apb(1'b1, 8'h08, bte_v);
    rd(8'h08, 33'(bte_v & 16'h1FFF));
    for (int i = 0; i < 4; i++) begin
      lim[i] = (i == 3) ? 16'h0001 : rnd() & ((i == 2) ? 16'h001F : 16'hFFFF);
      apb(1'b1, 8'(12 + 4 * i), lim[i]);
      rd(8'(12 + 4 * i), 33'(lim[i]));
    end
    apb(1'b1, 8'h00, 16'h8080);
    apb(1'b1, 8'h0C, ~lim[0]);
    apb(1'b1, 8'h08, ~bte_v);
    rd(8'h0C, 33'(lim[0]));
    rd(8'h08, 33'(bte_v & 16'h1FFF));
    cmd(8'h0F, l0);
    cmd(8'h00, l0);
    for (int i = 0; i < 13; i++) chk(33'(cnt[i]), 33'(bte_v[i]));
    rd(8'h1C, 33'h6);
    apb(1'b1, 8'h20, 16'h0002);
    @(negedge pclk);
    chk(33'(irq), 33'h1);
    apb(1'b1, 8'h1C, 16'h0002);
    @(negedge pclk);
    chk(33'(irq), 33'h0);
    cmd(8'h06, l1);
    cmd(8'h00, l1);
    chk(33'(l1 - l0), 33'(lim[2]) + 33'h1);
    // Wait on input 0 rising, once per input mode, delay enabled
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h00, 16'h8080 | 16'(m));
      fork
        cmd(8'h40, lat[m]);
        begin
          repeat (6) @(posedge pclk);
          trig_in_pins <= 16'h0001;
        end
      join
      trig_in_pins <= 16'h0000;
      repeat (4) @(posedge pclk);
    end
    chk(33'(lat[2] - lat[3]), 33'(lim[2]) + 33'h1);
    chk(33'(lat[0] - lat[1]), 33'(lim[2]) + 33'h1);
    // Soft trigger wait holds until software sets SWT
    fork
      cmd(8'h0B, l0);
      begin
        repeat (10) @(posedge pclk);
        apb(1'b1, 8'h00, 16'h8480);
      end
    join
    chk(33'(l0 > 10), 33'h1);
    cmd(8'hD5, l0);
    chk({jump_taken, jump_target}, 33'h35);
    cmd(8'hD5, l0);
    chk(33'(jump_taken), 33'h0);
    apb(1'b1, 8'h00, 16'h0000);
    apb(1'b1, 8'h0C, 16'h1234);
    rd(8'h0C, 33'h1234);
    // An 8-tick watchdog aborts a wait on an input that never moves
    apb(1'b1, 8'h04, 16'h0001);
    apb(1'b1, 8'h00, 16'h8080);
    cmd(8'h41, l0);
    chk(33'(l0), 33'h9);
    rd(8'h00, 33'h80C0);
    tally_and_finish();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
